// *** vco_band_vco_band_self_calibration_control_tb.sv ***
/* bench: one device on a tb driven port, one behind the host end.
   assumes a 10 MHz clock and tb drives after each rising edge. */
`timescale 1ns/100ps
`default_nettype none
module vco_band_vco_band_self_calibration_control_tb;
  import vco_cal_pkg::*;
  logic              clk, srst, lock; // clock, reset, lock level
  logic              pd_tick;         // pd pulse every 8 cycles
  logic [2:0]        pd_cnt;          // pd divider
  logic [31:0]       h_wdata;         // host order data
  logic              h_wr, h_busy;    // host order strobe, busy
  logic              sclk, sen, sdat, hold, busy;
  logic [INT_W-1:0]  pre;
  logic [DATA_W-1:0] frac;
  int                failures, total_checks, n;
  vco_cal_if bus_a ();
  vco_cal_if bus_b ();
  vco_cal_device vco_cal_device_inst (.I_REF_CLK(clk), .I_SRST(srst), .bus(bus_a),
    .I_LOCK_DETECT(lock), .I_VCO_TICK(1'b1), .I_PD_TICK(pd_tick),
    .O_VCO_SERIAL_CLOCK(sclk), .O_VCO_SERIAL_DATA(sdat), .O_VCO_SERIAL_EN(sen),
    .O_TUNE_HOLD(hold), .O_CAL_BUSY(busy), .O_PRESCALER_INT(pre),
    .O_MODULATOR_FRAC(frac));
  // second device, fed by the host end
  vco_cal_device peer_vco_cal_device_inst (.I_REF_CLK(clk), .I_SRST(srst), .bus(bus_b),
    .I_LOCK_DETECT(lock), .I_VCO_TICK(1'b1), .I_PD_TICK(pd_tick),
    .O_VCO_SERIAL_CLOCK(), .O_VCO_SERIAL_DATA(), .O_VCO_SERIAL_EN(),
    .O_TUNE_HOLD(), .O_CAL_BUSY(), .O_PRESCALER_INT(), .O_MODULATOR_FRAC());
  vco_cal_host vco_cal_host_inst (.I_REF_CLK(clk), .I_SRST(srst), .bus(bus_b),
    .I_ADDR(3'h0), .I_WDATA(h_wdata), .I_WR(h_wr), .I_RD(1'b0), .O_RDATA(),
    .O_BUSY(h_busy));
  vco_cal_chk vco_cal_chk_inst (.I_REF_CLK(clk), .I_SRST(srst), .wr(bus_a.wr),
    .rd(bus_a.rd), .addr(bus_a.addr), .wdata(bus_a.wdata), .rdata(bus_a.rdata),
    .I_LOCK_DETECT(lock), .O_VCO_SERIAL_CLOCK(sclk), .O_VCO_SERIAL_EN(sen),
    .O_TUNE_HOLD(hold), .O_CAL_BUSY(busy), .O_PRESCALER_INT(pre),
    .O_MODULATOR_FRAC(frac));
  // clock generator
  initial
  begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  // pd pulses; spacing keeps every count above the integer
  always @(posedge clk)
  begin
    pd_cnt <= pd_cnt + 3'h1;
    pd_tick <= (pd_cnt == 3'h7);
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      failures++;
      $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  // one write strobe, then one idle edge before the next
  task automatic wr_reg(input logic [5:0] a, input logic [23:0] d);
    bus_a.wr <= 1'b1;
    bus_a.addr <= a;
    bus_a.wdata <= d;
    @(posedge clk);
    bus_a.wr <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rd_reg(input logic [5:0] a, output logic [23:0] d);
    bus_a.rd <= 1'b1;
    bus_a.addr <= a;
    @(posedge clk);
    bus_a.rd <= 1'b0;
    @(posedge clk);
    d = bus_a.rdata;
  endtask
  task automatic wait_busy(input logic v, input int lim);
    n = 0;
    while (busy !== v && n < lim)
    begin
      @(posedge clk);
      n++;
    end
    if (busy !== v)
    begin
      failures++;
      $display("MISMATCH t=%0t busy wait ran out", $time);
      test_done();
    end
  endtask
  task automatic s_reset;
    logic [23:0] d;
    rd_reg(REG_READBACK, d);
    check(d, 32'h0);
    rd_reg(6'h3f, d);
    check(d, 32'h0);
  endtask
  // manual: forwarding word, then integer, then fraction
  task automatic s_manual;
    int k;
    logic [15:0] w; // link bits
    k = 0;
    wr_reg(REG_CAL, 24'h000800);
    wr_reg(REG_FWD, {8'h00, 9'h015, VCO_SW_REG, VCO_SUB_ID});
    repeat (60)
    begin
      @(posedge clk);
      if (sen === 1'b1 && sclk === 1'b1)
      begin
        k++;
        w = {w[14:0], sdat};
      end
    end
    check(k, 32'h10);
    check(w, {9'h015, VCO_SW_REG, VCO_SUB_ID});
    wr_reg(REG_INT, 24'h000003);
    check(pre, 32'h3);
    wr_reg(REG_FRAC, 24'h123456);
    check(frac, 32'h123456);
    check(busy, 32'h0);
  endtask
  // tick spacing for every clock select
  task automatic s_clock;
    logic [2:0] e;
    for (int s = 0; s < 4; s++)
    begin
      e = (s == 0) ? DIV_EXP0 : (s == 1) ? DIV_EXP1 : (s == 2) ? DIV_EXP2 : DIV_EXP3;
      wr_reg(REG_CAL, {9'h000, 2'(s), 13'h0800});
      repeat (3)
      begin
        n = 0;
        do begin @(posedge clk); n++; end while (sclk !== 1'b1 && n < 40);
      end
      check(n, 32'h1 << e);
    end
  endtask
  task automatic s_auto;
    logic [23:0] d;
    wr_reg(REG_CAL, 24'h000001);
    wr_reg(REG_MODE, 24'h000800);
    wr_reg(REG_FRAC, 24'h00abcd);
    check(frac, 32'h123456);
    wait_busy(1'b1, 10);
    check(hold, 32'h1);
    wr_reg(REG_FRAC, 24'h000111);
    rd_reg(REG_READBACK, d);
    check(d[BUSY_BIT], 32'h1);
    wait_busy(1'b0, 3000);
    check(frac, 32'h000111);
    repeat (10) @(posedge clk);
    check(busy, 32'h0);
    rd_reg(REG_READBACK, d);
    check(d, 32'h1f);
    wr_reg(REG_FRAC, 24'h000111);
    wait_busy(1'b1, 10);
    wait_busy(1'b0, 3000);
    check(frac, 32'h000111);
  endtask
  task automatic s_int;
    wr_reg(REG_MODE, 24'h000000);
    wr_reg(REG_INT, 24'h000005);
    check(pre, 32'h3);
    wait_busy(1'b1, 10);
    wait_busy(1'b0, 3000);
    check(pre, 32'h5);
  endtask
  // lock loss: one run only while lock stays lost
  task automatic s_relock;
    wr_reg(REG_LOCK, 24'h002000);
    lock <= 1'b0;
    wait_busy(1'b1, 20);
    wait_busy(1'b0, 3000);
    n = 0;
    repeat (300)
    begin
      @(posedge clk);
      if (busy !== 1'b0)
        n++;
    end
    check(n, 32'h0);
    lock <= 1'b1;
  endtask
  task automatic s_host;
    h_wr <= 1'b1;
    @(posedge clk);
    h_wr <= 1'b0;
    @(posedge clk);
    n = 0;
    while (h_busy !== 1'b0 && n < 3000)
    begin
      @(posedge clk);
      n++;
    end
    check(h_busy, 32'h0);
    check(bus_b.addr, REG_INT);
    check(bus_b.wdata, 32'h9);
  endtask
  task automatic test_done;
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  // main sequence
  initial
  begin
    srst = 1'b1;
    lock = 1'b0;
    pd_cnt = 3'h0;
    pd_tick = 1'b0;
    h_wdata = 32'h9;
    h_wr = 1'b0;
    bus_a.wr = 1'b0;
    bus_a.rd = 1'b0;
    bus_a.addr = 6'h00;
    bus_a.wdata = 24'h000000;
    failures = 0;
    total_checks = 0;
    repeat (5) @(posedge clk);
    srst <= 1'b0;
    lock <= 1'b1;
    @(posedge clk);
    s_reset();
    s_manual();
    s_clock();
    s_auto();
    s_int();
    s_relock();
    s_host();
    test_done();
  end
endmodule
`default_nettype wire

// *** vco_cal_chk.sv ***
/* checker for the device end on the tb driven port.
   assumes one clock domain and a sync active high reset. */
`timescale 1ns/100ps
`default_nettype none
module vco_cal_chk
  import vco_cal_pkg::*;
(
  input wire logic              I_REF_CLK,
  input wire logic              I_SRST,
  input wire logic              wr,
  input wire logic              rd,
  input wire logic [ADDR_W-1:0] addr,
  input wire logic [DATA_W-1:0] wdata,
  input wire logic [DATA_W-1:0] rdata,
  input wire logic              I_LOCK_DETECT,
  input wire logic              O_VCO_SERIAL_CLOCK,
  input wire logic              O_VCO_SERIAL_EN,
  input wire logic              O_TUNE_HOLD,
  input wire logic              O_CAL_BUSY,
  input wire logic [INT_W-1:0]  O_PRESCALER_INT,
  input wire logic [DATA_W-1:0] O_MODULATOR_FRAC
);
  logic       cal_dis;   // shadow of disable bit
  logic       frac_mode; // shadow of mode bit
  logic       relock_en; // shadow of relock bit
  logic [4:0] nticks;    // serial clocks in a transfer
  logic       en_q;      // enable one edge late
  logic       trig;      // write that must start a run
  assign trig = wr && !cal_dis && !O_CAL_BUSY
    && (addr == (frac_mode ? REG_FRAC : REG_INT));
  // shadows follow port writes, so they lag one edge
  always_ff @(posedge I_REF_CLK)
  begin
    if (I_SRST)
    begin
      cal_dis   <= 1'b0;
      frac_mode <= 1'b0;
      relock_en <= 1'b0;
    end
    else if (wr)
    begin
      if (addr == REG_CAL)
        cal_dis <= wdata[CAL_DIS_BIT];
      if (addr == REG_MODE)
        frac_mode <= wdata[FRAC_MODE_BIT];
      if (addr == REG_LOCK)
        relock_en <= wdata[AUTO_RELOCK_BIT];
    end
  end
  // clock lags the tick one edge, so enable lags too
  always_ff @(posedge I_REF_CLK)
  begin
    en_q <= O_VCO_SERIAL_EN;
    if (I_SRST || !en_q)
      nticks <= 5'h00;
    else if (O_VCO_SERIAL_CLOCK)
      nticks <= nticks + 5'h01;
  end
  default clocking cb @(posedge I_REF_CLK); endclocking
  default disable iff (I_SRST);
  sequence lock_lost;
    relock_en && !cal_dis && !O_CAL_BUSY && $fell(I_LOCK_DETECT);
  endsequence
  sequence cal_starts;
    ##[1:12] O_CAL_BUSY;
  endsequence
  cal_start_a: assert property (trig |-> cal_starts)
    else $error("no run after trigger write");
  relock_run_a: assert property (lock_lost |-> cal_starts)
    else $error("no run after lock loss");
  tune_hold_a: assert property (O_TUNE_HOLD == O_CAL_BUSY)
    else $error("tuning hold differs from busy");
  frac_hold_a: assert property (O_CAL_BUSY |-> $stable(O_MODULATOR_FRAC))
    else $error("fraction moved during run");
  int_hold_a: assert property (O_CAL_BUSY |-> $stable(O_PRESCALER_INT))
    else $error("integer moved during run");
  frac_now_a: assert property (wr && cal_dis && addr == REG_FRAC
    |=> O_MODULATOR_FRAC == $past(wdata)) else $error("fraction not loaded");
  int_now_a: assert property (wr && cal_dis && addr == REG_INT
    |=> {5'h00, O_PRESCALER_INT} == $past(wdata)) else $error("integer not loaded");
  link_len_a: assert property ($fell(en_q) |-> nticks == 5'h10)
    else $error("transfer length wrong");
  busy_read_a: assert property (rd && addr == REG_READBACK
    |=> rdata[BUSY_BIT] == $past(O_CAL_BUSY)) else $error("busy bit wrong");
endmodule
`default_nettype wire

// *** vco_cal_device.sv ***
/*
  device end: register file on the main port, vco band self
  calibration state machine, fsm clock divider and vco link.
  assumes vco and pd ticks are one-cycle pulses on I_REF_CLK and
  lock detect is an asynchronous level.
*/
`timescale 1ns/100ps
`default_nettype none
module vco_cal_device
  import vco_cal_pkg::*;
#(
  parameter int SW_W  = 5,  // switch bits of the step tuned vco
  parameter int CNT_W = 28  // vco edge counter width
)
(
  input  wire logic       I_REF_CLK,
  input  wire logic       I_SRST,
  vco_cal_if.device       bus,
  input  wire logic       I_LOCK_DETECT,
  input  wire logic       I_VCO_TICK,
  input  wire logic       I_PD_TICK,
  output logic            O_VCO_SERIAL_CLOCK,
  output logic            O_VCO_SERIAL_DATA,
  output logic            O_VCO_SERIAL_EN,
  output logic            O_TUNE_HOLD,
  output logic            O_CAL_BUSY,
  output logic [INT_W-1:0]  O_PRESCALER_INT,
  output logic [DATA_W-1:0] O_MODULATOR_FRAC
);
  typedef enum logic [2:0] {IDLE, SEND, SENDW, SETTLE, MEAS, DECIDE, LOAD} state_t;
  state_t state;                  // calibration sequencer

  logic [INT_W-1:0]  int_reg;     // integer register
  logic [DATA_W-1:0] frac_reg;    // fractional register
  logic [DATA_W-1:0] fwd_reg;     // forwarding register
  logic [DATA_W-1:0] mode_reg;    // mode register
  logic [DATA_W-1:0] lock_reg;    // lock control register
  logic [DATA_W-1:0] cal_reg;     // calibration config register
  logic [7:0]        sw_readback; // last chosen switch
  logic [4:0]        div_cnt;     // fsm clock divider
  logic [2:0]        div_exp;     // selected m
  logic              fsm_tick;    // one pulse per fsm clock
  logic              fwd_pend;    // host forwarding word waiting
  logic              trig_req;    // accepted calibration request
  logic              relock_req;  // pending relock attempt
  logic              relock_used; // attempt spent for this loss
  logic [2:0]        lock_sync;   // three stage sync
  logic              lock_ok;     // filtered lock level
  logic [SW_W-1:0]   best;        // switch kept so far
  logic [SW_W-1:0]   trial;       // candidate under test
  logic [3:0]        bit_idx;     // bit under test
  logic              last_send;   // final switch transfer
  logic [8:0]        wait_cnt;    // settle counter
  logic [8:0]        pd_cnt;      // pd periods counted
  logic [CNT_W-1:0]  vco_cnt;     // vco edges counted
  logic [CNT_W-1:0]  target;      // expected count
  logic              link_start;  // shifter start pulse
  logic [LINK_BITS-1:0] link_word;
  logic              link_busy;
  logic              link_done;
  logic              wr_int;
  logic              wr_frac;
  logic              wr_fwd;
  logic              frac_mode;
  logic              cal_dis;
  logic              trig;
  logic [2:0]        meas_n;
  logic [1:0]        wait_k;

  assign wr_int    = bus.wr && (bus.addr == REG_INT);
  assign wr_frac   = bus.wr && (bus.addr == REG_FRAC);
  assign wr_fwd    = bus.wr && (bus.addr == REG_FWD);
  assign frac_mode = mode_reg[FRAC_MODE_BIT];
  assign cal_dis   = cal_reg[CAL_DIS_BIT];
  assign meas_n    = cal_reg[MEAS_N_LSB +: 3];
  assign wait_k    = cal_reg[WAIT_K_LSB +: 2];
  // a same-value rewrite still counts as a change request
  assign trig      = !cal_dis && ((wr_frac && frac_mode) || (wr_int && !frac_mode));
  assign trial     = best | (SW_W'(1) << bit_idx);
  assign target    = CNT_W'(int_reg) << meas_n; // integer part only
  assign O_TUNE_HOLD = (state != IDLE);
  assign O_CAL_BUSY  = (state != IDLE);

  // main port register writes
  always_ff @(posedge I_REF_CLK)
  begin
    if (I_SRST)
    begin
      int_reg  <= '0;
      frac_reg <= '0;
      fwd_reg  <= '0;
      mode_reg <= '0;
      lock_reg <= '0;
      cal_reg  <= '0;
    end
    else if (bus.wr)
    begin
      unique case (bus.addr)
        REG_INT:  int_reg  <= bus.wdata[INT_W-1:0];
        REG_FRAC: frac_reg <= bus.wdata;
        REG_FWD:  fwd_reg  <= bus.wdata;
        REG_MODE: mode_reg <= bus.wdata;
        REG_LOCK: lock_reg <= bus.wdata;
        REG_CAL:  cal_reg  <= bus.wdata;
        default:  ; // unmapped writes dropped
      endcase
    end
  end

  // read data one cycle after the strobe; unmapped reads zero
  always_ff @(posedge I_REF_CLK)
  begin
    if (I_SRST)
      bus.rdata <= '0;
    else if (bus.rd)
    begin
      unique case (bus.addr)
        REG_INT:      bus.rdata <= DATA_W'(int_reg);
        REG_FRAC:     bus.rdata <= frac_reg;
        REG_FWD:      bus.rdata <= fwd_reg;
        REG_MODE:     bus.rdata <= mode_reg;
        REG_LOCK:     bus.rdata <= lock_reg;
        REG_CAL:      bus.rdata <= cal_reg;
        REG_READBACK: bus.rdata <= DATA_W'({O_CAL_BUSY, sw_readback});
        default:      bus.rdata <= '0;
      endcase
    end
  end

  // fsm clock: reference divided by 2^m, m from the select field
  always_comb
  begin
    unique case (cal_reg[CLK_SEL_LSB +: 2])
      2'h0:    div_exp = DIV_EXP0;
      2'h1:    div_exp = DIV_EXP1;
      2'h2:    div_exp = DIV_EXP2;
      default: div_exp = DIV_EXP3;
    endcase
  end
  assign fsm_tick = (div_cnt == 5'((6'h01 << div_exp) - 6'h01));

  always_ff @(posedge I_REF_CLK)
  begin
    if (I_SRST || fsm_tick)
      div_cnt <= '0;
    else
      div_cnt <= div_cnt + 5'h01;
  end

  // serial clock is the fsm tick registered one edge late, so link and fsm agree
  always_ff @(posedge I_REF_CLK)
  begin
    if (I_SRST)
      O_VCO_SERIAL_CLOCK <= 1'b0;
    else
      O_VCO_SERIAL_CLOCK <= fsm_tick;
  end

  // lock detect sync; level changes once stages two and three agree
  always_ff @(posedge I_REF_CLK)
  begin
    if (I_SRST)
    begin
      lock_sync <= '0;
      lock_ok   <= 1'b0;
    end
    else
    begin
      lock_sync <= {lock_sync[1:0], I_LOCK_DETECT};
      if (lock_sync[1] == lock_sync[2])
        lock_ok <= lock_sync[2];
    end
  end

  // relock bookkeeping: one attempt per loss, rearmed by relock
  always_ff @(posedge I_REF_CLK)
  begin
    if (I_SRST)
    begin
      relock_req  <= 1'b0;
      relock_used <= 1'b0;
    end
    else
    begin
      if (lock_ok)
        relock_used <= 1'b0;
      if (!lock_ok && lock_reg[AUTO_RELOCK_BIT] && !relock_used && !relock_req)
      begin
        relock_req  <= 1'b1;
        relock_used <= 1'b1;
      end
      else if (state == IDLE && !fwd_pend && relock_req && !trig_req)
        relock_req <= 1'b0;
    end
  end

  // requests while busy are dropped, not queued
  always_ff @(posedge I_REF_CLK)
  begin
    if (I_SRST)
      trig_req <= 1'b0;
    else if (trig && state == IDLE)
      trig_req <= 1'b1;
    else if (state == IDLE && !fwd_pend && trig_req)
      trig_req <= 1'b0;
  end

  // host forwarding words go out when the link is free; set wins
  always_ff @(posedge I_REF_CLK)
  begin
    if (I_SRST)
      fwd_pend <= 1'b0;
    else if (wr_fwd)
      fwd_pend <= 1'b1;
    else if (state == IDLE && !link_busy)
      fwd_pend <= 1'b0;
  end

  // link arbitration; calibration keeps the id field of the reg
  always_comb
  begin
    link_start = 1'b0;
    link_word  = fwd_reg[LINK_BITS-1:0];
    if (state == IDLE && fwd_pend && !link_busy)
      link_start = 1'b1;
    else if (state == SEND)
    begin
      link_start = 1'b1;
      link_word  = {FWD_DATA_W'(last_send ? best : trial), VCO_SW_REG,
                    fwd_reg[FWD_ID_W-1:0]};
    end
  end

  vco_link_shifter u_link (
    .i_clk   (I_REF_CLK),
    .i_srst  (I_SRST),
    .i_tick  (fsm_tick),
    .i_start (link_start),
    .i_word  (link_word),
    .o_data  (O_VCO_SERIAL_DATA),
    .o_busy  (link_busy),
    .o_done  (link_done)
  );
  assign O_VCO_SERIAL_EN = link_busy;

  // calibration sequencer: binary search msb first
  always_ff @(posedge I_REF_CLK)
  begin
    if (I_SRST)
    begin
      state     <= IDLE;
      best      <= '0;
      bit_idx   <= '0;
      last_send <= 1'b0;
      wait_cnt  <= '0;
      pd_cnt    <= '0;
      vco_cnt   <= '0;
    end
    else
    begin
      unique case (state)
        IDLE:
          if (!fwd_pend && (trig_req || relock_req))
          begin
            state     <= SEND;
            best      <= '0;
            bit_idx   <= 4'(SW_W - 1);
            last_send <= 1'b0;
          end
        SEND:
          if (!link_busy)
            state <= SENDW;
        SENDW:
          if (link_done)
          begin
            wait_cnt <= '0;
            pd_cnt   <= '0;
            vco_cnt  <= '0;
            state    <= last_send ? LOAD : SETTLE;
          end
        SETTLE:
          if (wait_cnt >= 9'(wait_k) * WAIT_UNIT)
            state <= MEAS;
          else if (fsm_tick)
            wait_cnt <= wait_cnt + 9'h001;
        MEAS:
        begin
          if (I_VCO_TICK)
            vco_cnt <= vco_cnt + CNT_W'(1);
          if (pd_cnt == (9'h001 << meas_n))
            state <= DECIDE;
          else if (I_PD_TICK)
            pd_cnt <= pd_cnt + 9'h001;
        end
        DECIDE:
        begin
          // more capacitance lowers frequency: keep bit if still fast
          if (vco_cnt > target)
            best <= trial;
          if (bit_idx == 4'h0)
            last_send <= 1'b1;
          else
            bit_idx <= bit_idx - 4'h1;
          state <= SEND;
        end
        LOAD:
          state <= IDLE;
        default:
          state <= IDLE;
      endcase
    end
  end

  // divider loads: at once when disabled, after calibration otherwise
  always_ff @(posedge I_REF_CLK)
  begin
    if (I_SRST)
    begin
      O_PRESCALER_INT  <= '0;
      O_MODULATOR_FRAC <= '0;
      sw_readback      <= '0;
    end
    else if (state == LOAD)
    begin
      O_PRESCALER_INT  <= int_reg;
      O_MODULATOR_FRAC <= frac_reg;
      sw_readback      <= 8'(best);
    end
    else if (cal_dis)
    begin
      if (wr_int)
        O_PRESCALER_INT <= bus.wdata[INT_W-1:0];
      if (wr_frac)
        O_MODULATOR_FRAC <= bus.wdata;
    end
  end
endmodule
`default_nettype wire

// *** vco_cal_host.sv ***
/*
  host end: takes frequency orders on a plain register port and
  issues the device writes in a safe order on the main port.
  assumes the device answers reads one cycle after the strobe.
*/
`timescale 1ns/100ps
`default_nettype none
module vco_cal_host
  import vco_cal_pkg::*;
(
  input  wire logic        I_REF_CLK,
  input  wire logic        I_SRST,
  vco_cal_if.host          bus,
  input  wire logic [2:0]  I_ADDR,
  input  wire logic [31:0] I_WDATA,
  input  wire logic        I_WR,
  input  wire logic        I_RD,
  output logic [31:0]      O_RDATA,
  output logic             O_BUSY
);
  localparam logic [2:0] H_INT    = 3'h0; // integer part
  localparam logic [2:0] H_FRAC   = 3'h1; // fraction, go in frac mode
  localparam logic [2:0] H_SWITCH = 3'h2; // [7:0] sw, [8] manual, [9] frac
  localparam logic [2:0] H_RAW    = 3'h3; // [29:24] addr, [23:0] data
  localparam logic [2:0] H_QUERY  = 3'h4; // [5:0] device read address
  localparam logic [2:0] H_STATUS = 3'h5; // [31] busy, [23:0] result

  logic [INT_W-1:0]  new_int;   // ordered integer part
  logic [INT_W-1:0]  sent_int;  // last integer sent
  logic [DATA_W-1:0] new_frac;  // ordered fraction
  logic [9:0]        sw_cfg;    // switch, manual flag, mode
  logic [31:0]       raw;       // raw write order
  logic [ADDR_W-1:0] query;     // read address
  logic [DATA_W-1:0] result;    // last read answer
  logic              pend_raw;
  logic              pend_fwd;
  logic              pend_int;
  logic              pend_frac;
  logic              pend_rd;
  logic              rd_wait;   // answer due this cycle
  logic              go;        // frequency order accepted

  assign O_BUSY = pend_raw || pend_fwd || pend_int || pend_frac || pend_rd || rd_wait;
  assign go = I_WR && !O_BUSY &&
              ((I_ADDR == H_FRAC && sw_cfg[9]) || (I_ADDR == H_INT && !sw_cfg[9]));

  // order storage; orders while busy are ignored
  always_ff @(posedge I_REF_CLK)
  begin
    if (I_SRST)
    begin
      new_int  <= '0;
      new_frac <= '0;
      sw_cfg   <= '0;
      raw      <= '0;
      query    <= '0;
    end
    else if (I_WR && !O_BUSY)
    begin
      unique case (I_ADDR)
        H_INT:    new_int  <= I_WDATA[INT_W-1:0];
        H_FRAC:   new_frac <= I_WDATA[DATA_W-1:0];
        H_SWITCH: sw_cfg   <= I_WDATA[9:0];
        H_RAW:    raw      <= I_WDATA; // id setup goes here first
        H_QUERY:  query    <= I_WDATA[ADDR_W-1:0];
        default:  ;
      endcase
    end
  end

  // issue queue: raw, switch, integer, trigger last, then read
  always_ff @(posedge I_REF_CLK)
  begin
    if (I_SRST)
    begin
      {pend_raw, pend_fwd, pend_int, pend_frac, pend_rd} <= '0;
      bus.wr    <= 1'b0;
      bus.rd    <= 1'b0;
      bus.addr  <= '0;
      bus.wdata <= '0;
      sent_int  <= '0;
      rd_wait   <= 1'b0;
      result    <= '0;
    end
    else
    begin
      bus.wr  <= 1'b0;
      bus.rd  <= 1'b0;
      rd_wait <= bus.rd;
      if (rd_wait)
        result <= bus.rdata;
      if (I_WR && !O_BUSY && I_ADDR == H_RAW)
        pend_raw <= 1'b1;
      else if (I_WR && !O_BUSY && I_ADDR == H_QUERY)
        pend_rd <= 1'b1;
      else if (go)
      begin
        pend_fwd  <= sw_cfg[8];
        pend_int  <= !sw_cfg[9] || (new_int != sent_int);
        pend_frac <= sw_cfg[9];
      end
      else if (pend_raw)
      begin
        pend_raw  <= 1'b0;
        bus.wr    <= 1'b1;
        bus.addr  <= raw[29:24];
        bus.wdata <= raw[DATA_W-1:0];
      end
      else if (pend_fwd)
      begin
        pend_fwd  <= 1'b0;
        bus.wr    <= 1'b1;
        bus.addr  <= REG_FWD;
        bus.wdata <= DATA_W'({FWD_DATA_W'(sw_cfg[7:0]), VCO_SW_REG, VCO_SUB_ID});
      end
      else if (pend_int)
      begin
        pend_int  <= 1'b0;
        bus.wr    <= 1'b1;
        bus.addr  <= REG_INT;
        bus.wdata <= DATA_W'(new_int);
        sent_int  <= new_int;
      end
      else if (pend_frac)
      begin
        pend_frac <= 1'b0; // trigger written last
        bus.wr    <= 1'b1;
        bus.addr  <= REG_FRAC;
        bus.wdata <= new_frac;
      end
      else if (pend_rd)
      begin
        pend_rd  <= 1'b0;
        bus.rd   <= 1'b1;
        bus.addr <= query;
      end
    end
  end

  // local read port, data one cycle after the strobe
  always_ff @(posedge I_REF_CLK)
  begin
    if (I_SRST)
      O_RDATA <= '0;
    else if (I_RD)
    begin
      unique case (I_ADDR)
        H_INT:    O_RDATA <= 32'(new_int);
        H_FRAC:   O_RDATA <= 32'(new_frac);
        H_SWITCH: O_RDATA <= 32'(sw_cfg);
        H_RAW:    O_RDATA <= raw;
        H_QUERY:  O_RDATA <= 32'(query);
        H_STATUS: O_RDATA <= {O_BUSY, 7'h00, result};
        default:  O_RDATA <= '0;
      endcase
    end
  end
endmodule
`default_nettype wire

// *** vco_cal_if.sv ***
/*
  main serial port carrier between host controller and device.
  assumes both ends share I_REF_CLK; read data one cycle after rd.
*/
`timescale 1ns/100ps
`default_nettype none
interface vco_cal_if;
  import vco_cal_pkg::*;
  logic              wr;    // write strobe, one cycle
  logic              rd;    // read strobe, one cycle
  logic [ADDR_W-1:0] addr;  // register offset
  logic [DATA_W-1:0] wdata; // write data
  logic [DATA_W-1:0] rdata; // read data, cycle after rd
  modport device (input wr, rd, addr, wdata, output rdata);
  modport host   (output wr, rd, addr, wdata, input rdata);
endinterface
`default_nettype wire

// *** vco_cal_pkg.sv ***
/*
  shared constants for the vco band self calibration pair: register
  offsets, field positions, link framing and timing figures.
  assumes both ends and the carrier import it whole.
*/
`default_nettype none
package vco_cal_pkg;
  // device register offsets on the main port
  localparam logic [5:0] REG_INT      = 6'h03;
  localparam logic [5:0] REG_FRAC     = 6'h04;
  localparam logic [5:0] REG_FWD      = 6'h05;
  localparam logic [5:0] REG_MODE     = 6'h06;
  localparam logic [5:0] REG_LOCK     = 6'h07;
  localparam logic [5:0] REG_CAL      = 6'h0a;
  localparam logic [5:0] REG_READBACK = 6'h10;
  localparam int ADDR_W = 6;  // main port address width
  localparam int DATA_W = 24; // main port data width
  localparam int INT_W  = 19; // integer divider width
  // field positions
  localparam int FRAC_MODE_BIT  = 11; // mode reg
  localparam int AUTO_RELOCK_BIT = 13; // lock reg
  localparam int CAL_DIS_BIT    = 11; // cal reg
  localparam int MEAS_N_LSB     = 0;  // cal reg [2:0]
  localparam int WAIT_K_LSB     = 6;  // cal reg [7:6]
  localparam int CLK_SEL_LSB    = 13; // cal reg [14:13]
  localparam int BUSY_BIT       = 8;  // readback reg
  // forwarding word: {data[8:0], vco reg[3:0], subsystem id[2:0]}
  localparam int FWD_ID_W   = 3;
  localparam int FWD_REG_W  = 4;
  localparam int FWD_DATA_W = 9;
  localparam logic [3:0] VCO_SW_REG = 4'h0; // switch register in vco
  localparam logic [2:0] VCO_SUB_ID = 3'h0; // arbitrary default id
  // link and timing
  localparam int LINK_BITS = 16;              // serial clocks per transfer
  localparam logic [8:0] WAIT_UNIT = 9'h064;  // 100 fsm cycles per k
  localparam logic [2:0] DIV_EXP0 = 3'h0;     // 2^m for each select
  localparam logic [2:0] DIV_EXP1 = 3'h2;
  localparam logic [2:0] DIV_EXP2 = 3'h4;
  localparam logic [2:0] DIV_EXP3 = 3'h5;
endpackage
`default_nettype wire

// *** vco_link_shifter.sv ***
/*
  serialiser for the internal vco link: one word, msb first, one bit
  per fsm tick. assumes tick is a one-cycle pulse on the same clock.
*/
`timescale 1ns/100ps
`default_nettype none
module vco_link_shifter
  import vco_cal_pkg::*;
(
  input  wire logic                 i_clk,
  input  wire logic                 i_srst,
  input  wire logic                 i_tick,
  input  wire logic                 i_start,
  input  wire logic [LINK_BITS-1:0] i_word,
  output logic                      o_data,
  output logic                      o_busy,
  output logic                      o_done
);
  logic [LINK_BITS-1:0] shift; // outgoing bits
  logic [4:0]           count; // bits already sent
  logic                 last;  // final bit on this tick

  assign last   = o_busy && i_tick && (count == 5'(LINK_BITS - 1));
  assign o_done = last;
  assign o_data = shift[LINK_BITS-1];

  // load on start, shift one bit per tick, 16 ticks in all
  always_ff @(posedge i_clk)
  begin
    if (i_srst)
    begin
      shift  <= '0;
      count  <= '0;
      o_busy <= 1'b0;
    end
    else if (i_start && !o_busy)
    begin
      shift  <= i_word;
      count  <= '0;
      o_busy <= 1'b1;
    end
    else if (o_busy && i_tick)
    begin
      shift <= {shift[LINK_BITS-2:0], 1'b0};
      count <= count + 5'h01;
      if (last)
        o_busy <= 1'b0;
    end
  end
endmodule
`default_nettype wire
